// ===== include/ppfs_defs.vh
`ifndef PPFS_DEFS_VH
`define PPFS_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPFS_OFF_DATA 5'h00
`define PPFS_OFF_DIR 5'h04
`define PPFS_OFF_PULLUP 5'h08
`define PPFS_OFF_PINS 5'h0C
`define PPFS_OFF_ROLE 5'h10
`define PPFS_OFF_FLAGS 5'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPFS_BIT_RST_PIN 5
`define PPFS_BIT_CLK_OUT 4
`define PPFS_BIT_CLK_IN 3
`define PPFS_ROLE_RST 0
`define PPFS_ROLE_CLK_IN 1
`define PPFS_ROLE_CLK_OUT 2
`define PPFS_ROLE_SEL_LSB 4
`define PPFS_ROLE_NVM 7
`define PPFS_ROLE_LOCKED 8
`define PPFS_FLAG_CLAIM 0

// ----------------------------------------------------------------
// clock option codes
// ----------------------------------------------------------------
`define PPFS_CLK_INT_RC 3'h0
`define PPFS_CLK_EXT_RC 3'h1
`define PPFS_CLK_EXT_CLK 3'h2
`define PPFS_CLK_XTAL 3'h3
`define PPFS_CLK_LF_XTAL 3'h4
`define PPFS_CLK_RESONATOR 3'h5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPFS_RST_DATA 6'h00
`define PPFS_RST_DIR 5'h00
`define PPFS_RST_PULLUP 5'h00
`define PPFS_RST_SEL 3'h0
`define PPFS_RST_RST_EN 1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPFS_CLK_PERIOD_NS 4
`define PPFS_RST_MIN_NS 50
`define PPFS_RST_MIN_CYC ((`PPFS_RST_MIN_NS + `PPFS_CLK_PERIOD_NS - 1) / `PPFS_CLK_PERIOD_NS)

`endif

// ===== logic/ppfs_sync2.v
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module ppfs_sync2 #(
  parameter W = 6
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ===== logic/ppfs_port_mux.v
`include "ppfs_defs.vh"
`default_nettype none

// What this block does
// - six general port pins, positions zero to five
// - lower five pins bidirectional, each with its own pull-up enable
// - without data memory the top pin is input only, never driven
// - with data memory the top pin is input or open-drain low driver
// - every pin floats while any reset is active, clock or not
// - reset and clock options claim top three pins over port use
// - reset enabled: top pin is reset input; else port input or open-drain
// - crystal, low-frequency crystal or resonator claim pins four and three
// - external RC or clock claim only pin three; internal RC claims none
// - reset option leaves pins three, four alone; clock option leaves pin five
// - low on enabled reset pin resets without clock; over 50 ns guaranteed
module ppfs_port_mux #(
  parameter HAS_DATA_NVM = 1,
  parameter NPINS = 6,
  parameter RST_STRETCH = `PPFS_RST_MIN_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire cfg_ext_reset_en,
  input wire [2:0] cfg_clock_sel,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [NPINS-1:0] general_port_pins_in,
  output reg [NPINS-1:0] general_port_pins_out,
  output reg [NPINS-1:0] general_port_pins_oe,
  output reg [NPINS-1:0] general_port_pins_pullup,
  output reg oscillator_amp_input_sel,
  output reg oscillator_amp_output_sel,
  output reg core_rst_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // one-hot: latch the options in hold, pass through latch, then run
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_LATCH = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg rst_en_reg;
  reg [2:0] clk_sel_reg;
  reg [5:0] data_reg;
  reg [4:0] dir_reg;
  reg [4:0] pullup_reg;
  reg claim_flag_reg;
  reg claim_flag_next;
  reg [7:0] stretch_reg;
  reg [31:0] rdata_next;
  reg [NPINS-1:0] out_next;
  reg [NPINS-1:0] oe_next;
  reg [NPINS-1:0] pu_next;
  wire [NPINS-1:0] pins_sync;
  wire ext_rst_hold;
  wire rst_all_n;
  wire req;
  wire acc;
  wire wr_b0;
  wire rst_role;
  reg clk_in_claim;
  reg clk_out_claim;
  wire [4:0] claimed_low;
  wire [5:0] role_bits;

  // ----------------------------------------------------------------
  // reset combining
  // ----------------------------------------------------------------
  // the raw pin goes straight into the asynchronous reset tree on
  // purpose: a synchroniser would need a running clock
  assign ext_rst_hold = rst_en_reg & ~general_port_pins_in[`PPFS_BIT_RST_PIN];
  assign rst_all_n = rst_n & ~ext_rst_hold;

  // the synchronised copy only feeds the pin status register
  ppfs_sync2 #(
    .W(NPINS)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(general_port_pins_in),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // option latch
  // ----------------------------------------------------------------
  // options are sampled in the clock after the chip reset lifts,
  // while the core is still held, and never again
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        state_next = ST_LATCH;
      end
      ST_LATCH: begin
        // the hold counter is loaded here, so leave at once
        state_next = ST_RUN;
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_HOLD;
      rst_en_reg <= `PPFS_RST_RST_EN;
      clk_sel_reg <= `PPFS_RST_SEL;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_HOLD) begin
        rst_en_reg <= cfg_ext_reset_en;
        clk_sel_reg <= cfg_clock_sel;
      end
    end
  end

  // core stays in reset a guaranteed minimum after any reset source
  always @(posedge ref_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      // a pin reset leaves the state in run, so the full hold starts here
      stretch_reg <= RST_STRETCH[7:0];
      core_rst_n <= 1'b0;
    end else begin
      if (state_reg != ST_RUN) begin
        stretch_reg <= RST_STRETCH[7:0];
        core_rst_n <= 1'b0;
      end else if (stretch_reg != 8'h00) begin
        stretch_reg <= stretch_reg - 8'h01;
        core_rst_n <= 1'b0;
      end else begin
        core_rst_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin roles
  // ----------------------------------------------------------------
  assign rst_role = rst_en_reg;
  // codes six and seven are unassigned and fall back to the internal
  // oscillator, so a stray option can never steal a port pin
  always @* begin
    clk_in_claim = 1'b0;
    clk_out_claim = 1'b0;
    case (clk_sel_reg)
      `PPFS_CLK_INT_RC: begin
        clk_in_claim = 1'b0;
        clk_out_claim = 1'b0;
      end
      `PPFS_CLK_EXT_RC: begin
        clk_in_claim = 1'b1;
        clk_out_claim = 1'b0;
      end
      `PPFS_CLK_EXT_CLK: begin
        clk_in_claim = 1'b1;
        clk_out_claim = 1'b0;
      end
      `PPFS_CLK_XTAL: begin
        clk_in_claim = 1'b1;
        clk_out_claim = 1'b1;
      end
      `PPFS_CLK_LF_XTAL: begin
        clk_in_claim = 1'b1;
        clk_out_claim = 1'b1;
      end
      `PPFS_CLK_RESONATOR: begin
        clk_in_claim = 1'b1;
        clk_out_claim = 1'b1;
      end
      default: begin
        clk_in_claim = 1'b0;
        clk_out_claim = 1'b0;
      end
    endcase
  end
  assign claimed_low = {clk_out_claim, clk_in_claim, 3'b000};
  assign role_bits = {1'b0, HAS_DATA_NVM != 0, clk_out_claim, clk_in_claim, 1'b0, rst_role};

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // a claimed pin is released entirely so the board part owns it
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_low
      always @* begin
        if (claimed_low[gi]) begin
          out_next[gi] = 1'b0;
          oe_next[gi] = 1'b0;
          pu_next[gi] = 1'b0;
        end else begin
          out_next[gi] = data_reg[gi];
          oe_next[gi] = dir_reg[gi];
          pu_next[gi] = pullup_reg[gi] & ~dir_reg[gi];
        end
      end
    end
  endgenerate

  // top pin never has a pull-up and never drives high
  // bit five of the data register doubles as its low-drive enable
  always @* begin
    out_next[`PPFS_BIT_RST_PIN] = 1'b0;
    pu_next[`PPFS_BIT_RST_PIN] = 1'b0;
    if (rst_role) begin
      oe_next[`PPFS_BIT_RST_PIN] = 1'b0;
    end else if (HAS_DATA_NVM != 0) begin
      oe_next[`PPFS_BIT_RST_PIN] = data_reg[`PPFS_BIT_RST_PIN];
    end else begin
      oe_next[`PPFS_BIT_RST_PIN] = 1'b0;
    end
  end

  // any reset source floats all pins at once, clock or not
  always @(posedge ref_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      general_port_pins_out <= {NPINS{1'b0}};
      general_port_pins_oe <= {NPINS{1'b0}};
      general_port_pins_pullup <= {NPINS{1'b0}};
      oscillator_amp_input_sel <= 1'b0;
      oscillator_amp_output_sel <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      general_port_pins_out <= {NPINS{1'b0}};
      general_port_pins_oe <= {NPINS{1'b0}};
      general_port_pins_pullup <= {NPINS{1'b0}};
      oscillator_amp_input_sel <= 1'b0;
      oscillator_amp_output_sel <= 1'b0;
    end else begin
      general_port_pins_out <= out_next;
      general_port_pins_oe <= oe_next;
      general_port_pins_pullup <= pu_next;
      oscillator_amp_input_sel <= clk_in_claim;
      oscillator_amp_output_sel <= clk_out_claim;
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // one wait cycle per access: waitrequest drops the cycle after the
  // request shows and the access takes effect at the following edge
  // writes with lane zero off are dropped whole; only lane zero has writable bits
  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;
  assign wr_b0 = avs_write & acc & avs_byteenable[0];

  // readback is captured in the wait cycle, so the address must hold
  always @* begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      `PPFS_OFF_DATA: begin
        rdata_next[5:0] = data_reg;
      end
      `PPFS_OFF_DIR: begin
        rdata_next[4:0] = dir_reg;
      end
      `PPFS_OFF_PULLUP: begin
        rdata_next[4:0] = pullup_reg;
      end
      `PPFS_OFF_PINS: begin
        rdata_next[NPINS-1:0] = pins_sync;
      end
      `PPFS_OFF_ROLE: begin
        rdata_next[`PPFS_ROLE_CLK_OUT:`PPFS_ROLE_RST] = {role_bits[3:2], role_bits[0]};
        rdata_next[`PPFS_ROLE_SEL_LSB+2:`PPFS_ROLE_SEL_LSB] = clk_sel_reg;
        rdata_next[`PPFS_ROLE_NVM] = role_bits[4];
        rdata_next[`PPFS_ROLE_LOCKED] = (state_reg == ST_RUN);
      end
      `PPFS_OFF_FLAGS: begin
        rdata_next[`PPFS_FLAG_CLAIM] = claim_flag_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // a write asking to drive a pin the options own is kept but has no
  // effect on the pin; the flag tells software it tried
  always @* begin
    claim_flag_next = claim_flag_reg;
    if (wr_b0 && avs_address == `PPFS_OFF_FLAGS && avs_writedata[`PPFS_FLAG_CLAIM]) begin
      claim_flag_next = 1'b0;
    end
    if (wr_b0 && avs_address == `PPFS_OFF_DIR && |(avs_writedata[4:0] & claimed_low)) begin
      claim_flag_next = 1'b1;
    end
    if (wr_b0 && avs_address == `PPFS_OFF_DATA && rst_role && avs_writedata[5]) begin
      claim_flag_next = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      data_reg <= `PPFS_RST_DATA;
      dir_reg <= `PPFS_RST_DIR;
      pullup_reg <= `PPFS_RST_PULLUP;
      claim_flag_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      claim_flag_reg <= claim_flag_next;
      if (req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= rdata_next;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_b0) begin
        case (avs_address)
          `PPFS_OFF_DATA: begin
            // bit five only exists as the open-drain low enable
            data_reg <= {avs_writedata[5] & (HAS_DATA_NVM != 0), avs_writedata[4:0]};
          end
          `PPFS_OFF_DIR: begin
            dir_reg <= avs_writedata[4:0];
          end
          `PPFS_OFF_PULLUP: begin
            pullup_reg <= avs_writedata[4:0];
          end
          default: begin
            dir_reg <= dir_reg;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/ppfs_asserts.sv
`default_nettype none
module ppfs_asserts #(
  parameter HAS_DATA_NVM = 1,
  parameter NPINS = 6,
  parameter RST_STRETCH = 13
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cfg_ext_reset_en,
  input wire logic [2:0] cfg_clock_sel,
  input wire logic [NPINS-1:0] general_port_pins_in,
  input wire logic [NPINS-1:0] general_port_pins_out,
  input wire logic [NPINS-1:0] general_port_pins_oe,
  input wire logic [NPINS-1:0] general_port_pins_pullup,
  input wire logic oscillator_amp_input_sel,
  input wire logic oscillator_amp_output_sel,
  input wire logic core_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [NPINS-1:0] oe = general_port_pins_oe;
  wire [NPINS-1:0] pu = general_port_pins_pullup;
  wire osc_i = oscillator_amp_input_sel;
  wire osc_o = oscillator_amp_output_sel;
  wire [2:0] cs = cfg_clock_sel;
  logic [7:0] low_cnt;
  // ----
  // core hold counter, saturating so a stuck reset cannot wrap it
  // ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      low_cnt <= 8'h00;
    else if (core_rst_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  end
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_core_up;
    !core_rst_n ##1 core_rst_n;
  endsequence
  a_reset_floats: assert property (
    $rose(rst_n) |-> oe == '0 && pu == '0) else $error("pins active after chip reset");
  a_pin_reset_floats: assert property (
    cfg_ext_reset_en && !general_port_pins_in[NPINS-1] |-> !core_rst_n && oe == '0)
    else $error("reset pin low but core or pins active");
  a_top_low_only: assert property (
    general_port_pins_out[NPINS-1] == 1'h0 && pu[NPINS-1] == 1'h0)
    else $error("top pin driven high or pulled up");
  a_top_input_only: assert property (
    HAS_DATA_NVM == 0 || cfg_ext_reset_en |-> !oe[NPINS-1]) else $error("top pin driven");
  a_pin3_claimed: assert property (
    osc_i |-> !oe[3] && !pu[3]) else $error("clock input pin used as port");
  a_pin4_claimed: assert property (
    osc_o |-> osc_i && !oe[4] && !pu[4]) else $error("clock output pin used as port");
  a_clock_roles: assert property (
    core_rst_n |-> osc_o == (cs >= 3'h3 && cs <= 3'h5) && osc_i == (cs >= 3'h1 && cs <= 3'h5))
    else $error("clock pin roles do not match option");
  a_pull_input_only: assert property (
    (pu & oe) == '0) else $error("pull-up on a driven pin");
  a_stretch_len: assert property (
    s_core_up |-> low_cnt >= RST_STRETCH) else $error("core reset released too early");
endmodule
bind ppfs_port_mux ppfs_asserts #(
  .HAS_DATA_NVM(HAS_DATA_NVM), .NPINS(NPINS), .RST_STRETCH(RST_STRETCH)
) ppfs_asserts_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .cfg_ext_reset_en(cfg_ext_reset_en),
  .cfg_clock_sel(cfg_clock_sel), .general_port_pins_in(general_port_pins_in),
  .general_port_pins_out(general_port_pins_out), .general_port_pins_oe(general_port_pins_oe),
  .general_port_pins_pullup(general_port_pins_pullup),
  .oscillator_amp_input_sel(oscillator_amp_input_sel),
  .oscillator_amp_output_sel(oscillator_amp_output_sel), .core_rst_n(core_rst_n)
);
`default_nettype wire

// ===== tb/ppfs_board.sv
`default_nettype none
module ppfs_board (
  input wire logic clk,
  input wire logic [5:0] drv,
  input wire logic [5:0] drv_en,
  input wire logic [5:0] pu_en,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] flick = 6'h2A;
  // a floating line toggles so no settled value can pass by luck
  always @(posedge clk)
    flick <= ~flick;
  // top pin sinks only; the reset line carries a board pull-up
  always_comb begin
    for (int i = 0; i < 6; i++)
      level[i] = drv_en[i] ? (i == 5 ? 1'h0 : drv[i]) : ext_en[i] ? ext_val[i] :
        (pu_en[i] || i == 5) ? 1'h1 : flick[i];
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STR = 2;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic rst_en = 1'h1;
  logic [2:0] sel = 3'h0;
  logic [4:0] adr = 5'h00;
  logic av_rd = 1'h0;
  logic av_wr = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ext_val = 6'h00;
  wire [31:0] rdat;
  wire wait_r;
  wire c_rst_n;
  wire osc_in_sel;
  wire osc_out_sel;
  wire [5:0] lvl, p_out, p_oe, p_pu;
  int n_errors = 0;
  int checks = 0;
  ppfs_port_mux #(.RST_STRETCH(STR)) ppfs_port_mux_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_ext_reset_en(rst_en), .cfg_clock_sel(sel),
    .avs_address(adr), .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(wdat),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .general_port_pins_in(lvl), .general_port_pins_out(p_out),
    .general_port_pins_oe(p_oe), .general_port_pins_pullup(p_pu),
    .oscillator_amp_input_sel(osc_in_sel), .oscillator_amp_output_sel(osc_out_sel),
    .core_rst_n(c_rst_n));
  ppfs_board ppfs_board_i (.clk(ref_clk), .drv(p_out), .drv_en(p_oe), .pu_en(p_pu),
    .ext_en(ext_en), .ext_val(ext_val), .level(lvl));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    av_rd <= !w;
    av_wr <= w;
    adr <= a;
    wdat <= d;
    @(posedge ref_clk);
    while (wait_r !== 1'h0 && k < 50) begin
      @(posedge ref_clk);
      k++;
    end
    q = rdat;
    if (k == 50)
      chk(32'h0, 32'h1);
    av_rd <= 1'h0;
    av_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_core();
    int k;
    k = 0;
    while (c_rst_n !== 1'h1 && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    chk(32'(c_rst_n), 32'h1);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_roles(input logic e, input logic [2:0] s);
    logic [5:0] cl;
    cl = {e, s >= 3'h3 && s <= 3'h5, s != 3'h0 && s <= 3'h5, 3'h0};
    rst_n <= 1'h0;
    rst_en <= e;
    sel <= s;
    ext_en <= {1'h0, cl[4:3], 3'h0};
    @(posedge ref_clk);
    chk(32'(p_oe), 32'h0);
    rst_n <= 1'h1;
    wait_core();
    chk(32'({osc_out_sel, osc_in_sel}), 32'(cl[4:3]));
    rd(5'h10, {23'h0, 2'h3, s, 1'h0, cl[4:3], e});
    rd(5'h1C, 32'h0);
    wr(5'h04, 32'h1F);
    wr(5'h00, 32'h35);
    @(posedge ref_clk);
    chk(32'(p_oe), 32'({~e, 5'h1F & ~cl[4:0]}));
    chk(32'(lvl & ~cl), 32'(6'h15 & ~cl));
    rd(5'h14, 32'(cl != 6'h00));
    wr(5'h14, 32'h1);
    rd(5'h14, 32'h0);
    wr(5'h04, 32'h0);
    wr(5'h08, 32'h1F);
    @(posedge ref_clk);
    chk(32'(p_pu), 32'(5'h1F & ~cl[4:0]));
    repeat (2) @(posedge ref_clk);
    rd(5'h0C, 32'({e, 5'h1F & ~cl[4:0]}));
  endtask
  task automatic t_pulse(input logic e);
    wr(5'h04, 32'h1F);
    ext_en <= 6'h20;
    ext_val <= 6'h00;
    // held 60 ns, past the guaranteed minimum
    repeat (15) @(posedge ref_clk);
    chk(32'(c_rst_n), 32'(!e));
    chk(32'(p_oe[4:0]), e ? 32'h0 : 32'h1F);
    ext_en <= 6'h00;
    wait_core();
    rd(5'h04, e ? 32'h0 : 32'h1F);
  endtask
  task automatic final_report();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 8; s++)
        t_roles(e[0], s[2:0]);
      t_pulse(e[0]);
    end
    final_report();
  end
  initial begin
    #40us;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
